// [hdl/bsf_buck_ctrl.sv]
// Buck setpoint selection, soft-start, fault status and open-drain interrupt
//
// Notes on behaviour
// - Normal setpoint drives the target; scaled setpoint while scaling mode is on.
// - Each setpoint is a 6-bit unsigned code used as a plain integer.
// - Target millivolts equal 600 plus code times 50.
// - Codes with upper bits 111 and lower bits 100 or above saturate at 3600.
// - Any unmasked status change pulls the interrupt line low.
// - Software masks each status change with its own unmask bit.
// - Line stays low until the host reads the status register.
// - If the fault persists after the read, the line stays low.
// - Interrupt pin only pulls low or floats, never drives high.
// - Live power-ok, overvoltage and current-limit per buck, each maskable.
// - Output ramps at 2.5 V/ms on every enable and after fault restart.
// - Scaling switch steps one code at a time; OV and UV ignored meanwhile.
// - Power-ok low raises interrupt when unmasked; read clears only once fault gone.
// - Two 125 percent cycles warn and interrupt; eight shut the buck down.
// - Each buck follows its host-written on bit until a fault shuts it down; any control write clears the shutdown.
`timescale 1ns/1ps
module bsf_buck_ctrl
  import bsf_pkg::*;
(
  // Clock and reset
  input  wire logic                          ref_clk_in,
  input  wire logic                          reset_in,
  // Serial register port
  input  wire logic                          i2c_scl_in,
  input  wire logic                          i2c_sda_in,
  output logic                               i2c_sda_out,
  output logic                               i2c_sda_oe_out,
  // Interrupt pin, open drain
  output logic                               interrupt_request_n_out,
  output logic                               interrupt_request_n_oe_out,
  // Regulator comparators, asynchronous
  input  wire logic [bsf_pkg::NUM_BUCKS-1:0] power_ok_in,
  input  wire logic [bsf_pkg::NUM_BUCKS-1:0] overvoltage_in,
  input  wire logic [bsf_pkg::NUM_BUCKS-1:0] undervoltage_in,
  input  wire logic [bsf_pkg::NUM_BUCKS-1:0] overcurrent_in,
  input  wire logic [bsf_pkg::NUM_BUCKS-1:0] switch_cycle_in,
  // Regulator controls
  output logic [bsf_pkg::NUM_BUCKS-1:0]      regulator_enable_out,
  output logic [bsf_pkg::NUM_BUCKS-1:0][11:0] target_mv_out
);
  import bsf_pkg::*;

  // Setpoint code to millivolts with top-code saturation
  function automatic logic [11:0] code_to_mv(input logic [5:0] code);
    if (code[5:3] == SAT_HI && code[2:0] >= SAT_LO)
      return MV_MAX;
    return MV_BASE + {6'h00, code} * MV_STEP;
  endfunction

  // Pin synchronisers
  bsf_pins_t pins_raw;
  bsf_pins_t meta_reg, sync_reg, prev_reg;
  assign pins_raw = '{scl: i2c_scl_in, sda: i2c_sda_in, power_ok_flag: power_ok_in,
                      ov: overvoltage_in, uv: undervoltage_in, oc: overcurrent_in,
                      tick: switch_cycle_in};
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      // Bus lines start at their pulled-up idle level, so no false edge follows reset
      meta_reg <= '{scl: 1'b1, sda: 1'b1, default: '0};
      sync_reg <= '{scl: 1'b1, sda: 1'b1, default: '0};
      prev_reg <= '{scl: 1'b1, sda: 1'b1, default: '0};
    end
    else
    begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Serial slave state
  bsf_ser_state_t st_reg, st_next;
  logic [3:0]     bits_reg, bits_next;
  logic [7:0]     sh_reg, sh_next;
  logic [7:0]     ptr_reg, ptr_next;
  logic           rw_reg, rw_next;
  logic           nack_reg, nack_next;
  logic           sda_oe_reg, sda_oe_next;
  logic           wr_en, rd_status;
  logic [7:0]     rd_data;
  logic           start_c, stop_c, rise_c, fall_c;

  // Regulator state
  logic [5:0]     nset_reg [NUM_BUCKS], nset_next [NUM_BUCKS];
  logic [5:0]     sset_reg [NUM_BUCKS], sset_next [NUM_BUCKS];
  logic [5:0]     appl_reg [NUM_BUCKS], appl_next [NUM_BUCKS];
  logic [11:0]    ramp_reg [NUM_BUCKS], ramp_next [NUM_BUCKS];
  logic [11:0]    tmr_reg  [NUM_BUCKS], tmr_next  [NUM_BUCKS];
  logic [11:0]    stp_reg  [NUM_BUCKS], stp_next  [NUM_BUCKS];
  logic [3:0]     occ_reg  [NUM_BUCKS], occ_next  [NUM_BUCKS];
  bsf_flags_t     mask_reg [NUM_BUCKS], mask_next [NUM_BUCKS];
  bsf_flags_t     live_reg [NUM_BUCKS], live_next [NUM_BUCKS];
  bsf_flags_t     pend_reg [NUM_BUCKS], pend_next [NUM_BUCKS];
  logic [NUM_BUCKS-1:0] on_reg, on_next, scale_reg, scale_next, shut_reg, shut_next;
  logic [NUM_BUCKS-1:0] en_reg, en_next;
  logic [NUM_BUCKS-1:0][11:0] tgt_reg, tgt_next;
  logic           irq_reg, irq_next;

  // Bus conditions from synchronised pins
  assign start_c = sync_reg.scl & prev_reg.scl & prev_reg.sda & ~sync_reg.sda;
  assign stop_c  = sync_reg.scl & prev_reg.scl & ~prev_reg.sda & sync_reg.sda;
  assign rise_c  = sync_reg.scl & ~prev_reg.scl;
  assign fall_c  = ~sync_reg.scl & prev_reg.scl;

  // Register read mux
  always_comb
  begin
    rd_data = 8'h00;
    for (int i = 0; i < NUM_BUCKS; i++)
    begin
      if (ptr_reg == REG_SET_BASE + 8'(2 * i))
        rd_data = {2'h0, nset_reg[i]};
      if (ptr_reg == REG_SET_BASE + 8'(2 * i + 1))
        rd_data = {2'h0, sset_reg[i]};
      if (ptr_reg == REG_APPLIED + 8'(i))
        rd_data = {2'h0, appl_reg[i]};
    end
    case (ptr_reg)
      REG_CTRL:    rd_data = {4'h0, scale_reg, on_reg};
      REG_UNMASK:  rd_data = {2'h0, mask_reg[1], mask_reg[0]};
      REG_STATUS:  rd_data = {shut_reg, live_reg[1], live_reg[0]};
      REG_PENDING: rd_data = {2'h0, pend_reg[1], pend_reg[0]};
      default:     rd_data = rd_data;
    endcase
  end

  // Serial slave next state
  always_comb
  begin
    st_next     = st_reg;
    bits_next   = bits_reg;
    sh_next     = sh_reg;
    ptr_next    = ptr_reg;
    rw_next     = rw_reg;
    nack_next   = nack_reg;
    sda_oe_next = sda_oe_reg;
    wr_en       = 1'b0;
    rd_status   = 1'b0;
    if (start_c)
    begin
      st_next     = BSF_ADDR;
      bits_next   = 4'h0;
      sda_oe_next = 1'b0;
    end
    else if (stop_c)
    begin
      st_next     = BSF_IDLE;
      sda_oe_next = 1'b0;
    end
    else if (rise_c)
    begin
      case (st_reg)
        BSF_ADDR, BSF_PTR, BSF_WDATA:
        begin
          sh_next   = {sh_reg[6:0], sync_reg.sda};
          bits_next = bits_reg + 4'h1;
        end
        BSF_RACK: nack_next = sync_reg.sda;
        default:  nack_next = nack_reg;
      endcase
    end
    else if (fall_c)
    begin
      case (st_reg)
        BSF_ADDR:
          if (bits_reg == 4'h8)
          begin
            st_next     = (sh_reg[7:1] == DEV_ADDR) ? BSF_ADDR_ACK : BSF_IDLE;
            sda_oe_next = (sh_reg[7:1] == DEV_ADDR);
            rw_next     = sh_reg[0];
          end
        BSF_PTR:
          if (bits_reg == 4'h8)
          begin
            ptr_next    = sh_reg;
            bits_next   = 4'h0;                                 // Pointer ack: no advance
            st_next     = BSF_ACK;
            sda_oe_next = 1'b1;
          end
        BSF_WDATA:
          if (bits_reg == 4'h8)
          begin
            wr_en       = 1'b1;
            st_next     = BSF_ACK;
            sda_oe_next = 1'b1;
          end
        BSF_ACK:
        begin
          // Of the write acks, only the one after a data byte advances the pointer
          if (bits_reg == 4'h8)
            ptr_next = ptr_reg + 8'h01;
          st_next     = BSF_WDATA;
          bits_next   = 4'h0;
          sda_oe_next = 1'b0;
        end
        BSF_ADDR_ACK, BSF_RACK:
        begin
          if (!rw_reg)
          begin
            st_next     = BSF_PTR;
            bits_next   = 4'h0;
            sda_oe_next = 1'b0;
          end
          else if (st_reg == BSF_RACK && nack_reg)
          begin
            st_next     = BSF_IDLE;
            sda_oe_next = 1'b0;
          end
          else
          begin
            sh_next     = rd_data;
            sda_oe_next = ~rd_data[7];
            rd_status   = (ptr_reg == REG_STATUS);
            ptr_next    = ptr_reg + 8'h01;
            bits_next   = 4'h1;
            st_next     = BSF_RDATA;
          end
        end
        BSF_RDATA:
          if (bits_reg == 4'h8)
          begin
            sda_oe_next = 1'b0;
            st_next     = BSF_RACK;
          end
          else
          begin
            sh_next     = {sh_reg[6:0], 1'b0};
            sda_oe_next = ~sh_reg[6];
            bits_next   = bits_reg + 4'h1;
          end
        default: st_next = BSF_IDLE;
      endcase
    end
  end

  // Serial slave registers
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      st_reg     <= BSF_IDLE;
      bits_reg   <= 4'h0;
      sh_reg     <= 8'h00;
      ptr_reg    <= 8'h00;
      rw_reg     <= 1'b0;
      nack_reg   <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      st_reg     <= st_next;
      bits_reg   <= bits_next;
      sh_reg     <= sh_next;
      ptr_reg    <= ptr_next;
      rw_reg     <= rw_next;
      nack_reg   <= nack_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  // Regulator next state: setpoints, ramp, faults, pending flags
  always_comb
  begin
    logic [5:0]  sel;
    logic        en;
    logic        trans;
    bsf_flags_t  fl;
    bsf_flags_t  fault;
    sel   = 6'h00;
    en    = 1'b0;
    trans = 1'b0;
    fl    = '0;
    fault = '0;
    on_next    = on_reg;
    scale_next = scale_reg;
    shut_next  = shut_reg;
    irq_next   = 1'b0;
    for (int i = 0; i < NUM_BUCKS; i++)
    begin
      nset_next[i] = nset_reg[i];
      sset_next[i] = sset_reg[i];
      mask_next[i] = mask_reg[i];
      if (wr_en && ptr_reg == REG_SET_BASE + 8'(2 * i))
        nset_next[i] = sh_reg[5:0];
      if (wr_en && ptr_reg == REG_SET_BASE + 8'(2 * i + 1))
        sset_next[i] = sh_reg[5:0];
      if (wr_en && ptr_reg == REG_UNMASK)
        mask_next[i] = sh_reg[3*i +: 3];
      if (wr_en && ptr_reg == REG_CTRL)
      begin
        on_next[i]    = sh_reg[i];
        scale_next[i] = sh_reg[NUM_BUCKS + i];
        shut_next[i]  = 1'b0;
      end
      sel   = scale_reg[i] ? sset_reg[i] : nset_reg[i];
      en    = on_reg[i] & ~shut_reg[i];
      trans = en & (appl_reg[i] != sel);
      appl_next[i] = appl_reg[i];
      stp_next[i]  = 12'h000;
      ramp_next[i] = 12'h000;
      tmr_next[i]  = 12'h000;
      if (!en)
        appl_next[i] = sel;
      else if (trans)
      begin
        stp_next[i] = stp_reg[i] + 12'h001;
        if (stp_reg[i] == 12'(DVS_STEP_CYC - 1))
        begin
          stp_next[i]  = 12'h000;
          appl_next[i] = (appl_reg[i] < sel) ? appl_reg[i] + 6'h01
                                             : appl_reg[i] - 6'h01;
        end
      end
      if (en)
      begin
        ramp_next[i] = ramp_reg[i];
        tmr_next[i]  = tmr_reg[i] + 12'h001;
        if (tmr_reg[i] == 12'(SS_CYC_PER_MV - 1))
        begin
          tmr_next[i] = 12'h000;
          if (ramp_reg[i] < MV_MAX)
            ramp_next[i] = ramp_reg[i] + 12'h001;
        end
      end
      tgt_next[i] = (ramp_reg[i] < code_to_mv(appl_reg[i])) ? ramp_reg[i]
                                                            : code_to_mv(appl_reg[i]);
      en_next[i]  = en;
      // Count consecutive switching cycles at 125 percent of limit
      occ_next[i] = occ_reg[i];
      if (!en)
        occ_next[i] = 4'h0;
      else if (sync_reg.tick[i] && !prev_reg.tick[i])
        occ_next[i] = !sync_reg.oc[i] ? 4'h0
                    : (occ_reg[i] < OC_TRIP_CYC) ? occ_reg[i] + 4'h1 : occ_reg[i];
      if (occ_reg[i] >= OC_TRIP_CYC)
        shut_next[i] = 1'b1;
      if (en && !trans && sync_reg.uv[i] && ramp_reg[i] >= code_to_mv(appl_reg[i]))
        shut_next[i] = 1'b1;
      fl.power_ok_flag  = sync_reg.power_ok_flag[i];
      fl.ov   = sync_reg.ov[i] & ~trans;
      fl.ilim = (occ_reg[i] >= OC_WARN_CYC);
      fault.power_ok_flag  = en & ~fl.power_ok_flag;
      fault.ov   = fl.ov;
      fault.ilim = fl.ilim;
      live_next[i] = fl;
      // Clear on status read only where the fault is gone; a new change wins
      pend_next[i] = pend_reg[i];
      if (rd_status)
        pend_next[i] = pend_reg[i] & fault;
      pend_next[i] = pend_next[i] | ((fl ^ live_reg[i]) & mask_reg[i]);
      irq_next = irq_next | (|pend_next[i]);
    end
  end

  // Regulator registers
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      on_reg    <= RST_ON;
      scale_reg <= RST_SCALE;
      shut_reg  <= '0;
      en_reg    <= '0;
      tgt_reg   <= '0;
      irq_reg   <= 1'b0;
      for (int i = 0; i < NUM_BUCKS; i++)
      begin
        nset_reg[i] <= RST_NORMAL_CODE;
        sset_reg[i] <= RST_SCALED_CODE;
        appl_reg[i] <= RST_NORMAL_CODE;
        ramp_reg[i] <= 12'h000;
        tmr_reg[i]  <= 12'h000;
        stp_reg[i]  <= 12'h000;
        occ_reg[i]  <= 4'h0;
        mask_reg[i] <= RST_UNMASK;
        live_reg[i] <= '0;
        pend_reg[i] <= '0;
      end
    end
    else
    begin
      on_reg    <= on_next;
      scale_reg <= scale_next;
      shut_reg  <= shut_next;
      en_reg    <= en_next;
      tgt_reg   <= tgt_next;
      irq_reg   <= irq_next;
      nset_reg  <= nset_next;
      sset_reg  <= sset_next;
      appl_reg  <= appl_next;
      ramp_reg  <= ramp_next;
      tmr_reg   <= tmr_next;
      stp_reg   <= stp_next;
      occ_reg   <= occ_next;
      mask_reg  <= mask_next;
      live_reg  <= live_next;
      pend_reg  <= pend_next;
    end
  end

  // Pins only ever pull low; level outputs are tied to zero
  assign i2c_sda_out                = 1'b0 & sda_oe_reg;
  assign i2c_sda_oe_out             = sda_oe_reg;
  assign interrupt_request_n_out    = 1'b0 & irq_reg;
  assign interrupt_request_n_oe_out = irq_reg;
  assign regulator_enable_out       = en_reg;
  assign target_mv_out              = tgt_reg;
endmodule

// [hdl/bsf_pkg.sv]
// Constants, register map and carrier types for the buck setpoint and fault block
package bsf_pkg;
  localparam int          NUM_BUCKS       = 2;
  // Reference clock and soft-start slope
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          SS_MV_PER_MS    = 2500;
  localparam int          SS_CYC_PER_MV   = CLK_HZ / (SS_MV_PER_MS * 1000);
  localparam int          STEP_MV         = 50;
  localparam int          DVS_STEP_CYC    = SS_CYC_PER_MV * STEP_MV;
  // Setpoint decode in millivolts
  localparam logic [11:0] MV_BASE         = 12'h258;
  localparam logic [11:0] MV_STEP         = 12'h032;
  localparam logic [11:0] MV_MAX          = 12'hE10;
  localparam logic [2:0]  SAT_HI          = 3'h7;
  localparam logic [2:0]  SAT_LO          = 3'h4;
  // Overcurrent cycle counts
  localparam logic [3:0]  OC_WARN_CYC     = 4'h2;
  localparam logic [3:0]  OC_TRIP_CYC     = 4'h8;
  // Serial slave address and register offsets
  localparam logic [6:0]  DEV_ADDR        = 7'h25;
  localparam logic [7:0]  REG_SET_BASE    = 8'h00;
  localparam logic [7:0]  REG_CTRL        = 8'h04;
  localparam logic [7:0]  REG_UNMASK      = 8'h05;
  localparam logic [7:0]  REG_STATUS      = 8'h06;
  localparam logic [7:0]  REG_PENDING     = 8'h07;
  localparam logic [7:0]  REG_APPLIED     = 8'h08;
  // Values after reset
  localparam logic [5:0]  RST_NORMAL_CODE = 6'h0C;
  localparam logic [5:0]  RST_SCALED_CODE = 6'h0A;
  localparam logic [1:0]  RST_ON          = 2'h0;
  localparam logic [1:0]  RST_SCALE       = 2'h0;
  localparam logic [2:0]  RST_UNMASK      = 3'h7;

  typedef struct packed {
    logic ilim;
    logic ov;
    logic power_ok_flag;
  } bsf_flags_t;

  typedef struct packed {
    logic                 scl;
    logic                 sda;
    logic [NUM_BUCKS-1:0] power_ok_flag;
    logic [NUM_BUCKS-1:0] ov;
    logic [NUM_BUCKS-1:0] uv;
    logic [NUM_BUCKS-1:0] oc;
    logic [NUM_BUCKS-1:0] tick;
  } bsf_pins_t;

  typedef enum logic [3:0] {
    BSF_IDLE, BSF_ADDR, BSF_ADDR_ACK, BSF_PTR, BSF_ACK, BSF_WDATA, BSF_RDATA, BSF_RACK
  } bsf_ser_state_t;
endpackage

// [verification/bsf_buck_ctrl_checker.sv]
// Checker for the buck setpoint and fault block
`timescale 1ns/1ps
module bsf_buck_ctrl_checker
(
  // Clock and reset
  input wire logic                                 ref_clk_in,
  input wire logic                                 reset_in,
  // Serial port
  input wire logic                                 i2c_scl_in,
  input wire logic                                 i2c_sda_in,
  input wire logic                                 i2c_sda_out,
  input wire logic                                 i2c_sda_oe_out,
  // Interrupt pin
  input wire logic                                 interrupt_request_n_out,
  input wire logic                                 interrupt_request_n_oe_out,
  // Regulator side
  input wire logic [bsf_pkg::NUM_BUCKS-1:0]        power_ok_in,
  input wire logic [bsf_pkg::NUM_BUCKS-1:0]        overvoltage_in,
  input wire logic [bsf_pkg::NUM_BUCKS-1:0]        undervoltage_in,
  input wire logic [bsf_pkg::NUM_BUCKS-1:0]        overcurrent_in,
  input wire logic [bsf_pkg::NUM_BUCKS-1:0]        switch_cycle_in,
  input wire logic [bsf_pkg::NUM_BUCKS-1:0]        regulator_enable_out,
  input wire logic [bsf_pkg::NUM_BUCKS-1:0][11:0]  target_mv_out
);
  import bsf_pkg::*;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);
  logic [7:0] idle_reg;
  logic [7:0] idle_next;
  logic [3:0] oc_reg;
  logic [3:0] oc_next;
  logic       scl_d_reg;
  logic       sw_d_reg;
  // Bus idle time and consecutive overcurrent cycles on buck 1
  always_comb
  begin
    idle_next = (idle_reg == 8'hFF) ? idle_reg : idle_reg + 8'h01;
    if (i2c_scl_in != scl_d_reg)
    begin
      idle_next = 8'h00;
    end
    oc_next = oc_reg;
    if (switch_cycle_in[1] && !sw_d_reg)
    begin
      oc_next = !overcurrent_in[1] ? 4'h0 : ((oc_reg == 4'h8) ? oc_reg : oc_reg + 4'h1);
    end
  end
  // Helper registers
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      idle_reg <= 8'hFF;
      oc_reg <= 4'h0;
      scl_d_reg <= 1'b1;
      sw_d_reg <= 1'b0;
    end
    else
    begin
      idle_reg <= idle_next;
      oc_reg <= oc_next;
      scl_d_reg <= i2c_scl_in;
      sw_d_reg <= switch_cycle_in[1];
    end
  end
  chk_irq_never_high: assert property (interrupt_request_n_out == 1'b0)
    else $error("interrupt pin driven high");
  chk_release_after_read: assert property ($fell(interrupt_request_n_oe_out) |-> idle_reg < 8'hC8)
    else $error("interrupt released without bus access");
  chk_target_ceiling: assert property (target_mv_out[0] <= MV_MAX && target_mv_out[1] <= MV_MAX)
    else $error("target above ceiling");
  chk_ramp_from_zero: assert property ($rose(regulator_enable_out[0]) |-> target_mv_out[0] <= 12'h002)
    else $error("ramp not starting low");
  chk_ramp_slow_start: assert property ($rose(regulator_enable_out[0]) |-> ##40 target_mv_out[0] <= 12'h002)
    else $error("ramp too fast");
  chk_ramp_keeps_rising: assert property ($rose(regulator_enable_out[1]) |-> ##200 (!regulator_enable_out[1] || target_mv_out[1] >= 12'h003))
    else $error("ramp not rising");
  chk_enable_by_host: assert property ($rose(regulator_enable_out[1]) |-> idle_reg < 8'hC8)
    else $error("enable without host write");
  chk_oc_shutdown: assert property (oc_reg == 4'h8 && $past(oc_reg) == 4'h7 |-> ##[1:10] !regulator_enable_out[1])
    else $error("no shutdown after overcurrent");
  cov_irq: cover property ($rose(interrupt_request_n_oe_out));
  cov_enable: cover property ($rose(regulator_enable_out[0]));
  cov_trip: cover property ($fell(regulator_enable_out[1]));
endmodule

bind bsf_buck_ctrl bsf_buck_ctrl_checker i_chk (.ref_clk_in, .reset_in, .i2c_scl_in, .i2c_sda_in,
  .i2c_sda_out, .i2c_sda_oe_out, .interrupt_request_n_out, .interrupt_request_n_oe_out,
  .power_ok_in, .overvoltage_in, .undervoltage_in, .overcurrent_in, .switch_cycle_in,
  .regulator_enable_out, .target_mv_out);

// [verification/bsf_host_model.sv]
// Host processor model: serial register master on pulled-up lines
`timescale 1ns/1ps
module bsf_host_model
(
  // Clock
  input  wire logic ref_clk_in,
  // Resolved data line and own drivers
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  import bsf_pkg::*;
  // Lines released at start
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Wait reference clocks; two of them make a quarter bit
  task automatic tk(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // One bit: data set while clock low, sampled while high
  task automatic bit_io(input logic b, output logic r);
    tk(2);
    sda_low_out = !b;
    tk(2);
    scl_out = 1'b1;
    tk(2);
    r = sda_in;
    tk(2);
    scl_out = 1'b0;
  endtask
  // Eight bits, most significant first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
  endtask
  // Start, or repeated start after a byte
  task automatic start();
    tk(2);
    sda_low_out = 1'b0;
    tk(2);
    scl_out = 1'b1;
    tk(2);
    sda_low_out = 1'b1;
    tk(4);
    scl_out = 1'b0;
  endtask
  // Stop condition
  task automatic stop();
    tk(2);
    sda_low_out = 1'b1;
    tk(2);
    scl_out = 1'b1;
    tk(2);
    sda_low_out = 1'b0;
    tk(6);
  endtask
  // Register write: address, pointer, one data byte
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({DEV_ADDR, 1'b0}, q);
    byte_io(a, q);
    byte_io(d, q);
    stop();
  endtask
  // Register read, last byte not acknowledged
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    start();
    byte_io({DEV_ADDR, 1'b0}, q);
    byte_io(a, q);
    start();
    byte_io({DEV_ADDR, 1'b1}, q);
    byte_io(8'hFF, d);
    stop();
  endtask
endmodule

// [verification/testbench.sv]
// Self-checking testbench for the buck setpoint and fault block
`timescale 1ns/1ps
module testbench;
  import bsf_pkg::*;
  logic                       ref_clk;
  logic                       rst;
  logic                       scl;
  logic                       sda_low;
  logic                       sda_out;
  logic                       sda_oe;
  logic                       irq_out;
  logic                       irq_oe;
  logic [NUM_BUCKS-1:0]       power_ok_flag, ov, uv, oc, sw, en;
  logic [NUM_BUCKS-1:0][11:0] tgt;
  logic [7:0]                 q;
  int                         err_count;
  int                         num_checks;
  wire                        sda_w = (sda_oe ? sda_out : 1'b1) & !sda_low;
  wire                        irq_w = irq_oe ? irq_out : 1'b1;
  // Reference clock
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  bsf_buck_ctrl i_dut (.ref_clk_in(ref_clk), .reset_in(rst), .i2c_scl_in(scl),
    .i2c_sda_in(sda_w), .i2c_sda_out(sda_out), .i2c_sda_oe_out(sda_oe),
    .interrupt_request_n_out(irq_out), .interrupt_request_n_oe_out(irq_oe),
    .power_ok_in(power_ok_flag), .overvoltage_in(ov), .undervoltage_in(uv), .overcurrent_in(oc),
    .switch_cycle_in(sw), .regulator_enable_out(en), .target_mv_out(tgt));
  bsf_host_model i_host (.ref_clk_in(ref_clk), .sda_in(sda_w), .scl_out(scl),
    .sda_low_out(sda_low));
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Compare seen against expected
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    i_host.read_reg(a, q);
    chk(nm, {4'h0, q}, {4'h0, exp});
  endtask
  // Switching cycles on buck 1
  task automatic pulse(input int n);
    repeat (n)
    begin
      sw[1] = 1'b1;
      cyc(4);
      sw[1] = 1'b0;
      cyc(4);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog well past the roughly 65000 cycles the tests need
  initial
  begin
    #900000;
    err_count++;
    tally_and_finish();
  end
  // Test sequence
  initial
  begin
    {rst, power_ok_flag, ov, uv, oc, sw} = {1'b1, 2'h3, 8'h00};
    err_count = 0;
    num_checks = 0;
    cyc(12);
    rst = 1'b0;
    cyc(5);
    i_host.read_reg(REG_STATUS, q);
    i_host.read_reg(REG_STATUS, q);
    chk("irq idle", irq_w, 1'b1);
    rd_chk(8'h00, {2'h0, RST_NORMAL_CODE}, "normal 0");
    rd_chk(8'h01, {2'h0, RST_SCALED_CODE}, "scaled 0");
    rd_chk(8'h02, {2'h0, RST_NORMAL_CODE}, "normal 1");
    rd_chk(REG_CTRL, 8'h00, "ctrl");
    rd_chk(REG_UNMASK, 8'h3F, "unmask");
    rd_chk(8'h0A, 8'h00, "unmapped");
    i_host.write_reg(8'h03, 8'h0B);
    rd_chk(8'h03, 8'h0B, "scaled 1");
    $display("test registers done");
    // Soft-start to the default setpoints
    i_host.write_reg(REG_CTRL, 8'h03);
    cyc(4000);
    chk("ramp early", tgt[0] >= 12'h05F && tgt[0] <= 12'h069, 1'b1);
    cyc(44500);
    chk("target 0", tgt[0], 12'h4B0);
    chk("target 1", tgt[1], 12'h4B0);
    $display("test ramp done");
    // Scaling on buck 0 steps down to the scaled code
    i_host.write_reg(REG_CTRL, 8'h07);
    cyc(2500);
    rd_chk(REG_APPLIED, 8'h0B, "one step");
    // Undervoltage and overvoltage during the step are ignored
    {uv[0], ov[0]} = 2'h3;
    cyc(10);
    chk("uv ignored", en[0], 1'b1);
    chk("ov ignored", irq_w, 1'b1);
    {uv[0], ov[0]} = 2'h0;
    cyc(5000);
    rd_chk(REG_APPLIED, 8'h0A, "applied");
    chk("scaled target", tgt[0], 12'h44C);
    chk("other target", tgt[1], 12'h4B0);
    $display("test scaling done");
    // Power-ok, masking and overvoltage events
    i_host.read_reg(REG_STATUS, q);
    power_ok_flag[0] = 1'b0;
    cyc(10);
    chk("irq pok", irq_w, 1'b0);
    rd_chk(REG_STATUS, 8'h08, "status pok");
    cyc(4);
    chk("irq held", irq_w, 1'b0);
    power_ok_flag[0] = 1'b1;
    cyc(10);
    rd_chk(REG_STATUS, 8'h09, "status ok");
    cyc(4);
    chk("irq cleared", irq_w, 1'b1);
    i_host.write_reg(REG_UNMASK, 8'h3E);
    power_ok_flag[0] = 1'b0;
    cyc(10);
    power_ok_flag[0] = 1'b1;
    cyc(10);
    chk("irq masked", irq_w, 1'b1);
    i_host.write_reg(REG_UNMASK, 8'h3F);
    ov[1] = 1'b1;
    cyc(10);
    chk("irq ov", irq_w, 1'b0);
    rd_chk(REG_STATUS, 8'h19, "status ov");
    chk("irq ov held", irq_w, 1'b0);
    ov[1] = 1'b0;
    cyc(10);
    i_host.read_reg(REG_STATUS, q);
    cyc(4);
    chk("irq ov gone", irq_w, 1'b1);
    $display("test interrupts done");
    // Overcurrent warning, trip on the eighth cycle, restart
    oc[1] = 1'b1;
    pulse(2);
    cyc(10);
    chk("irq warn", irq_w, 1'b0);
    pulse(5);
    chk("on at 7", en[1], 1'b1);
    pulse(1);
    cyc(4);
    chk("off at 8", en[1], 1'b0);
    i_host.read_reg(REG_STATUS, q);
    chk("shut flag", q[7], 1'b1);
    oc[1] = 1'b0;
    i_host.write_reg(REG_CTRL, 8'h07);
    cyc(4);
    chk("restart", en, 2'h3);
    i_host.write_reg(REG_CTRL, 8'h05);
    cyc(4);
    chk("buck 1 off", en, 2'h1);
    // Undervoltage outside a step shuts the buck down
    uv[0] = 1'b1;
    cyc(10);
    chk("uv shutdown", en[0], 1'b0);
    $display("test overcurrent done");
    tally_and_finish();
  end
endmodule
